// [logic/acs_top.sv]
// Purpose: control and sequencing of a 10-bit successive approximation converter
// Assumes: comparator answer CMP_I valid at every bit tick, registers on a plain port
// Notes: read data stand one cycle after the read strobe only
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/100ps
// Function
// - completion flag sets at every conversion end, regardless of interrupt enable
// - separate interrupt enable gates the flag onto the request
// - converter interrupt works in run and sleep, and wakes from sleep
// - after wake the core runs on, vectoring only if global interrupts allow
// - three-bit clock select picks divide 2..64 or the rc clock
// - rc selection takes bit period from the free-running internal oscillator
// - format bit selects left or right justified 10-bit result
// - channel field in bits 5..2 routes the analog input
// - writing one to bit 1 with enable bit 0 set starts conversion, reads one while busy
// - hardware clears the start bit when conversion finishes
// - enable bit 0 powers the converter; clear means powered down
module acs_top import acs_pkg::*; (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic [DATA_W-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [DATA_W-1:0] RDATA_O,
    input wire logic CMP_I,
    input wire logic SLEEP_I,
    input wire logic GIE_I,
    output logic CONV_POWER_O,
    output logic [3:0] MUX_SEL_O,
    output logic [RES_W-1:0] TRIAL_O,
    output logic BUSY_O,
    output logic IRQ_O,
    output logic WAKE_O,
    output logic VECTOR_O
);
    typedef struct packed {
        acs_state_t state;
        logic [3:0] chs;
        logic go;
        logic on;
        logic fmt;
        logic [2:0] csel;
        logic flag;
        logic ien;
        logic [RES_W-1:0] trial;
        logic [BIT_W-1:0] bitn;
        logic [RES_W-1:0] res;
        logic [DATA_W-1:0] rdata;
    } acs_top_t;

    acs_top_t s_q;
    acs_top_t s_d;
    logic tick;
    logic done_evt;
    logic [RES_W-1:0] kept;
    logic [RES_W-1:0] onehot;
    logic [DATA_W-1:0] res_hi;
    logic [DATA_W-1:0] res_lo;
    logic wr_ctrl0;
    logic start_ok;

    acs_clkdiv #(
        .CNT_W(6),
        .RC_CYC(RC_TAD_CYC)
    ) u_div (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .sel_i(s_q.csel),
        .run_i(s_q.state == ACS_CONV),
        .sleep_i(SLEEP_I),
        .tick_o(tick)
    );

    always_comb begin
        s_d = s_q;
        s_d.rdata = '0;
        done_evt = 1'b0;
        onehot = RES_W'(1) << s_q.bitn;
        // a low comparator answer drops the trial bit, a high one keeps it
        kept = CMP_I ? s_q.trial : (s_q.trial & ~onehot);
        wr_ctrl0 = WR_I && (ADDR_I == OFF_CTRL0);
        start_ok = WDATA_I[CTRL0_GO_BIT] && WDATA_I[CTRL0_ON_BIT];

        // successive approximation, one bit per conversion tick
        unique case (s_q.state)
            ACS_IDLE: begin
                s_d.trial = '0;
            end
            ACS_CONV: begin
                if (tick) begin
                    if (s_q.bitn == '0) begin
                        s_d.res = kept;
                        s_d.trial = '0;
                        s_d.go = 1'b0;
                        s_d.state = ACS_IDLE;
                        done_evt = 1'b1;
                    end else begin
                        s_d.bitn = s_q.bitn - BIT_W'(1);
                        s_d.trial = kept | (onehot >> 1);
                    end
                end
            end
        endcase

        // result justification
        if (s_q.fmt) begin
            res_hi = {6'h00, s_q.res[9:8]};
            res_lo = s_q.res[7:0];
        end else begin
            res_hi = s_q.res[9:2];
            res_lo = {s_q.res[1:0], 6'h00};
        end

        if (wr_ctrl0) begin
            s_d.chs = WDATA_I[CTRL0_CHS_LSB +: 4];
            s_d.on = WDATA_I[CTRL0_ON_BIT];
            if (!WDATA_I[CTRL0_ON_BIT]) begin
                // powering down aborts a running conversion without a flag
                s_d.go = 1'b0;
                s_d.state = ACS_IDLE;
                s_d.trial = '0;
                done_evt = 1'b0;
            end else if (s_q.state == ACS_IDLE && start_ok) begin
                s_d.go = 1'b1;
                s_d.state = ACS_CONV;
                s_d.bitn = MSB_INDEX;
                s_d.trial = TRIAL_MSB;
            end
        end
        if (WR_I && ADDR_I == OFF_CTRL2) begin
            s_d.fmt = WDATA_I[CTRL2_FMT_BIT];
            s_d.csel = WDATA_I[CTRL2_CS_LSB +: 3];
        end
        if (WR_I && ADDR_I == OFF_IEN) begin
            s_d.ien = WDATA_I[DONE_BIT];
        end
        // write one clears; a completion in the same cycle wins
        if (WR_I && ADDR_I == OFF_FLAG && WDATA_I[DONE_BIT]) begin
            s_d.flag = 1'b0;
        end
        if (done_evt) begin
            s_d.flag = 1'b1;
        end

        if (RD_I) begin
            unique case (ADDR_I)
                OFF_CTRL0: begin
                    s_d.rdata = {2'h0, s_q.chs, s_q.go, s_q.on};
                end
                OFF_CTRL2: begin
                    s_d.rdata = {s_q.fmt, 4'h0, s_q.csel};
                end
                OFF_RES_HI: begin
                    s_d.rdata = res_hi;
                end
                OFF_RES_LO: begin
                    s_d.rdata = res_lo;
                end
                OFF_FLAG: begin
                    s_d.rdata = {7'h00, s_q.flag};
                end
                OFF_IEN: begin
                    s_d.rdata = {7'h00, s_q.ien};
                end
                default: begin
                    s_d.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            s_q.state <= ACS_IDLE;
            s_q.chs <= CHS_RST;
            s_q.go <= 1'b0;
            s_q.on <= 1'b0;
            s_q.fmt <= 1'b0;
            s_q.csel <= CS_RST;
            s_q.flag <= 1'b0;
            s_q.ien <= 1'b0;
            s_q.trial <= '0;
            s_q.bitn <= '0;
            s_q.res <= '0;
            s_q.rdata <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign RDATA_O = s_q.rdata;
    assign CONV_POWER_O = s_q.on;
    assign MUX_SEL_O = s_q.chs;
    assign TRIAL_O = s_q.trial;
    assign BUSY_O = s_q.go;
    assign IRQ_O = s_q.flag && s_q.ien;
    // wake is independent of the global enable; the core decides vectoring
    assign WAKE_O = SLEEP_I && IRQ_O;
    assign VECTOR_O = IRQ_O && GIE_I && !SLEEP_I;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    done_sets_flag_a: assert property (done_evt |=> s_q.flag)
        else $error("completion did not set the flag");
    flag_stays_a: assert property (
        (s_q.flag && !(WR_I && ADDR_I == OFF_FLAG && WDATA_I[DONE_BIT])) |=> s_q.flag)
        else $error("flag cleared without software");
    irq_gate_a: assert property (IRQ_O == (s_q.flag && s_q.ien))
        else $error("interrupt request not flag and enable");
    ien_write_a: assert property (
        (WR_I && ADDR_I == OFF_IEN) |=> (s_q.ien == $past(WDATA_I[DONE_BIT])))
        else $error("interrupt enable write lost");
    sleep_wake_a: assert property ((SLEEP_I && s_q.flag && s_q.ien) |-> WAKE_O)
        else $error("no wake from sleep on interrupt");
    vector_gie_a: assert property (VECTOR_O |-> (GIE_I && IRQ_O && !SLEEP_I))
        else $error("vector without global enable");
    start_busy_a: assert property (
        (wr_ctrl0 && start_ok && s_q.state == ACS_IDLE) |=> (s_q.go ##1 s_q.go))
        else $error("start did not raise busy");
    off_no_start_a: assert property (
        (wr_ctrl0 && !WDATA_I[CTRL0_ON_BIT]) |=> (!s_q.go && s_q.state == ACS_IDLE))
        else $error("start taken while disabled");
    done_clears_go_a: assert property (
        (s_q.state == ACS_CONV && tick && s_q.bitn == '0 && !wr_ctrl0) |=> !s_q.go)
        else $error("start bit not cleared at completion");
    power_pin_a: assert property (
        wr_ctrl0 |=> (CONV_POWER_O == $past(WDATA_I[CTRL0_ON_BIT])))
        else $error("power output does not follow enable");
    right_fmt_a: assert property (
        (RD_I && ADDR_I == OFF_RES_HI && s_q.fmt) |=> (RDATA_O[7:2] == 6'h00))
        else $error("right justified high byte not zero filled");
    left_fmt_a: assert property (
        (RD_I && ADDR_I == OFF_RES_LO && !s_q.fmt) |=> (RDATA_O[5:0] == 6'h00))
        else $error("left justified low byte not zero filled");
    chan_route_a: assert property (
        wr_ctrl0 |=> (MUX_SEL_O == $past(WDATA_I[5:2])))
        else $error("channel select not routed");
endmodule

// [inc/acs_pkg.sv]
// Purpose: shared constants and types of the converter control sequencer
// Assumes: 125 MHz system clock, 8-bit register port
// Notes: offsets are word indices on the plain register port
package acs_pkg;
    localparam int CLK_PERIOD_NS = 8;
    // typical bit period of the dedicated rc clock
    localparam int RC_TAD_NS = 1700;
    localparam int RC_TAD_CYC = (RC_TAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int RES_W = 10;
    localparam int BIT_W = 4;

    localparam logic [2:0] OFF_CTRL0 = 3'h0;
    localparam logic [2:0] OFF_CTRL2 = 3'h1;
    localparam logic [2:0] OFF_RES_HI = 3'h2;
    localparam logic [2:0] OFF_RES_LO = 3'h3;
    localparam logic [2:0] OFF_FLAG = 3'h4;
    localparam logic [2:0] OFF_IEN = 3'h5;

    localparam int CTRL0_ON_BIT = 0;
    localparam int CTRL0_GO_BIT = 1;
    localparam int CTRL0_CHS_LSB = 2;
    localparam int CTRL2_FMT_BIT = 7;
    localparam int CTRL2_CS_LSB = 0;
    localparam int DONE_BIT = 0;

    localparam logic [3:0] CHS_RST = 4'h0;
    localparam logic [2:0] CS_RST = 3'h0;
    localparam logic [3:0] MSB_INDEX = 4'h9;
    localparam logic [9:0] TRIAL_MSB = 10'h200;

    localparam logic [2:0] CS_DIV2 = 3'h0;
    localparam logic [2:0] CS_DIV4 = 3'h4;
    localparam logic [2:0] CS_DIV8 = 3'h1;
    localparam logic [2:0] CS_DIV16 = 3'h5;
    localparam logic [2:0] CS_DIV32 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h6;
    localparam logic [1:0] CS_RC_LOW = 2'h3;

    localparam logic [5:0] LAST_DIV2 = 6'h01;
    localparam logic [5:0] LAST_DIV4 = 6'h03;
    localparam logic [5:0] LAST_DIV8 = 6'h07;
    localparam logic [5:0] LAST_DIV16 = 6'h0F;
    localparam logic [5:0] LAST_DIV32 = 6'h1F;
    localparam logic [5:0] LAST_DIV64 = 6'h3F;

    typedef enum logic {
        ACS_IDLE,
        ACS_CONV
    } acs_state_t;
endpackage

// [logic/acs_clkdiv.sv]
// Purpose: per-bit conversion tick from the divided system clock or the rc clock
// Assumes: system divider halts in sleep, rc oscillator keeps running
// Notes: one-cycle tick, registered
`timescale 1ns/100ps
module acs_clkdiv import acs_pkg::*; #(
    parameter int CNT_W = 6,
    parameter int RC_CYC = RC_TAD_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] sel_i,
    input wire logic run_i,
    input wire logic sleep_i,
    output logic tick_o
);
    localparam int RC_W = $clog2(RC_CYC + 1);

    generate
        if (CNT_W < 6 || RC_CYC < 1) begin : g_bad
            $error("acs_clkdiv: divider too narrow or rc period empty");
        end
    endgenerate

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [RC_W-1:0] rc;
        logic tick;
    } acs_div_t;

    acs_div_t s_q;
    acs_div_t s_d;
    logic [CNT_W-1:0] last;
    logic rc_wrap;

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        unique case (sel_i)
            CS_DIV2: last = CNT_W'(LAST_DIV2);
            CS_DIV4: last = CNT_W'(LAST_DIV4);
            CS_DIV8: last = CNT_W'(LAST_DIV8);
            CS_DIV16: last = CNT_W'(LAST_DIV16);
            CS_DIV32: last = CNT_W'(LAST_DIV32);
            CS_DIV64: last = CNT_W'(LAST_DIV64);
            default: last = CNT_W'(LAST_DIV2);
        endcase
        // rc oscillator free-runs, so its phase does not follow the conversion start
        rc_wrap = (s_q.rc == RC_W'(RC_CYC - 1));
        s_d.rc = rc_wrap ? '0 : s_q.rc + RC_W'(1);
        if (!run_i) begin
            s_d.cnt = '0;
        end else if (sel_i[1:0] == CS_RC_LOW) begin
            s_d.tick = rc_wrap;
        end else if (!sleep_i) begin
            if (s_q.cnt >= last) begin
                s_d.cnt = '0;
                s_d.tick = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_o = s_q.tick;

    rc_period_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.rc < RC_W'(RC_CYC))
        else $error("rc counter beyond its period");
    div_spacing_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.tick && $past(sel_i) == CS_DIV4 && $past(sel_i, 2) == CS_DIV4
         && $past(sel_i, 3) == CS_DIV4)
        |-> (!$past(s_q.tick) && !$past(s_q.tick, 2) && !$past(s_q.tick, 3)))
        else $error("divide by four tick spacing wrong");
endmodule

// [sim/acs_core_model.sv]
// Purpose: analog mux and comparator seen from the sequencer's far side
// Assumes: each channel holds the level_i word xor its own channel code
// Notes: answers at once; unpowered or floating inputs give a toggling answer
`timescale 1ns/100ps
module acs_core_model import acs_pkg::*; (
    input wire logic clk_i,
    input wire logic power_i,
    input wire logic [3:0] sel_i,
    input wire logic [RES_W-1:0] trial_i,
    input wire logic [RES_W-1:0] level_i,
    output logic cmp_o
);
    logic junk_q = 1'b0;
    logic floating;

    // a settled 0 or 1 would hide a sequencer that samples with no input
    always_ff @(posedge clk_i) begin
        junk_q <= ~junk_q;
    end

    // reserved codes are left open, so their answer is noise
    assign floating = (sel_i < 4'h3) || (sel_i == 4'hC) || (sel_i == 4'hD);

    always_comb begin
        if (!power_i || floating) begin
            cmp_o = junk_q;
        end else begin
            cmp_o = ((level_i ^ {6'h00, sel_i}) >= trial_i);
        end
    end
endmodule

// [sim/test_acs_top.sv]
// Purpose: self-checking bench of the converter control sequencer
// Assumes: core model answers the comparator from a per-channel level
// Notes: conversion length is only bounded, the rc tick phase is free
`timescale 1ns/100ps
module test_acs_top import acs_pkg::*; ;
    logic clk, rst, wr, rd, cmp, sleep, gie, power, busy, irq, wake, vec, ien_v;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [3:0] mux;
    logic [RES_W-1:0] trial, level;
    int mismatches, samples_checked;
    logic [3:0] chs_tab [11] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hE, 4'hF};
    logic [2:0] cs_tab [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    int div_tab [8] = '{2, 4, 8, 16, 32, 64, RC_TAD_CYC, RC_TAD_CYC};

    acs_top DUT (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .CMP_I(cmp), .SLEEP_I(sleep), .GIE_I(gie),
        .CONV_POWER_O(power), .MUX_SEL_O(mux), .TRIAL_O(trial), .BUSY_O(busy),
        .IRQ_O(irq), .WAKE_O(wake), .VECTOR_O(vec));
    acs_core_model core (.clk_i(clk), .power_i(power), .sel_i(mux), .trial_i(trial),
        .level_i(level), .cmp_o(cmp));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task test_done;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
            mismatches++;
        end
    endtask

    task wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task wait_idle(output int n);
        n = 0;
        while (busy !== 1'b0) begin
            @(posedge clk);
            #1 n++;
            if (n > 3000) begin
                chk("busy_timeout", 16'h0001, 16'h0000);
                test_done;
            end
        end
    endtask

    task run_conv(input logic [3:0] chs, input logic [2:0] cs, input int div, input logic fmt);
        logic [RES_W-1:0] res;
        logic [DATA_W-1:0] d;
        int n;
        res = level ^ {6'h00, chs};
        wr_reg(OFF_CTRL2, {fmt, 4'h0, cs});
        wr_reg(OFF_FLAG, 8'h01);
        wr_reg(OFF_CTRL0, {2'b00, chs, 2'b11});
        chk("busy", busy, 1'b1);
        chk("mux_sel", mux, chs);
        chk("power", power, 1'b1);
        chk("trial_msb", trial, TRIAL_MSB);
        wait_idle(n);
        chk("trial_idle", trial, 10'h000);
        chk("tad_min", n >= 9 * div - 2, 1'b1);
        chk("tad_max", n <= 11 * div + 4, 1'b1);
        rd_reg(OFF_CTRL0, d);
        chk("ctrl0", d, {2'b00, chs, 2'b01});
        rd_reg(OFF_FLAG, d);
        chk("flag", d, 8'h01);
        chk("irq", irq, ien_v);
        rd_reg(OFF_RES_HI, d);
        chk("res_hi", d, fmt ? {6'h00, res[9:8]} : res[9:2]);
        rd_reg(OFF_RES_LO, d);
        chk("res_lo", d, fmt ? res[7:0] : {res[1:0], 6'h00});
    endtask

    task test_reset;
        logic [DATA_W-1:0] d;
        wr_reg(3'h6, 8'hFF);
        for (int i = 0; i < 8; i++) begin
            rd_reg(i[2:0], d);
            chk("reset_reg", d, 8'h00);
        end
        chk("reset_out", {power, busy, irq, trial}, 16'h0000);
        $display("test reset done");
    endtask

    task test_clocks;
        // fast dividers break the minimum bit period here the model has no minimum
        for (int i = 0; i < 11; i++) begin
            run_conv(chs_tab[i], cs_tab[i % 8], div_tab[i % 8], i[0]);
        end
        $display("test clocks done");
    endtask

    task test_irq;
        logic [DATA_W-1:0] d;
        wr_reg(OFF_IEN, 8'h01);
        @(posedge clk);
        gie <= 1'b1;
        ien_v = 1'b1;
        run_conv(4'h5, CS_DIV2, 2, 1'b0);
        chk("vector", vec, 1'b1);
        chk("wake", wake, 1'b0);
        repeat (20) @(posedge clk);
        #1 chk("flag_sticky", irq, 1'b1);
        wr_reg(OFF_FLAG, 8'h01);
        chk("irq_clear", irq, 1'b0);
        rd_reg(OFF_FLAG, d);
        chk("flag_clear", d, 8'h00);
        $display("test irq done");
    endtask

    task test_sleep;
        @(posedge clk);
        sleep <= 1'b1;
        // rc clock used here, the only one that keeps running while asleep
        run_conv(4'hE, {1'b1, CS_RC_LOW}, RC_TAD_CYC, 1'b1);
        chk("wake", wake, 1'b1);
        chk("no_vector", vec, 1'b0);
        @(posedge clk);
        sleep <= 1'b0;
        @(posedge clk);
        #1 chk("vector_after", vec, 1'b1);
        wr_reg(OFF_IEN, 8'h00);
        ien_v = 1'b0;
        chk("irq_masked", irq, 1'b0);
        $display("test sleep done");
    endtask

    task test_off;
        logic [DATA_W-1:0] d;
        wr_reg(OFF_CTRL0, 8'h00);
        wr_reg(OFF_CTRL0, 8'h0E);
        chk("off_busy", busy, 1'b0);
        chk("off_power", power, 1'b0);
        rd_reg(OFF_CTRL0, d);
        chk("off_ctrl0", d, 8'h0C);
        $display("test off done");
    endtask

    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = '0;
        wdata = '0;
        sleep = 1'b0;
        gie = 1'b0;
        level = 10'h2B5;
        ien_v = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        test_reset;
        test_clocks;
        test_irq;
        test_sleep;
        test_off;
        test_done;
    end
endmodule
